// File: core/sc_pkg.sv
// constants for the start/stop generator with collision detection
// assumes a single core clock domain; pins arrive unsynchronised
package sc_pkg;
  localparam int unsigned RELOAD_W       = 7;
  localparam int unsigned STAT_START_BIT = 3;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_LOW_W     = 5;
  localparam int unsigned BUF_W          = 8;
  localparam logic [6:0]  RELOAD_RST     = 7'h00;
  localparam logic [7:0]  BUF_RST        = 8'h00;
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  localparam logic [1:0]  SETTLE_CNT     = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_S_WAIT = 3'b001,
    ST_S_HOLD = 3'b010,
    ST_P_REL  = 3'b011,
    ST_P_HIGH = 3'b100,
    ST_P_SAMP = 3'b101
  } state_t;
endpackage

// File: core/start_stop_gen.sv
// start and stop generator for a shared two-wire bus, with collision detection
// assumes open-drain pins resolved outside; pin levels are asynchronous
`timescale 1ns/10ps
`default_nettype none
module start_stop_gen (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // software side
  input  wire logic [6:0] rate_reload_field_i,
  input  wire logic       ctrl_we_i,
  input  wire logic [4:0] ctrl_wdata_i,
  input  wire logic       stop_req_i,
  input  wire logic       buf_we_i,
  input  wire logic [7:0] buf_wdata_i,
  input  wire logic       clr_collision_i,
  input  wire logic       clr_write_clash_i,
  output logic [4:0]      master_control_two_o,
  output logic [7:0]      shift_buffer_o,
  output logic            start_seen_o,
  output logic            collision_flag_o,
  output logic            write_clash_flag_o,
  output logic            busy_o,
  // bus pins, open drain
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            scl_o,
  output logic            scl_oe_o
);
  sc_pkg::state_t state_q, state_d;
  logic [1:0] sda_s_q, scl_s_q;
  logic [6:0] cnt_q;
  logic [4:0] ctrl_q;
  logic [7:0] buf_q;
  logic       start_seen_q, coll_q, wclash_q, sda_low_q, scl_low_q;
  logic       stop_pend_q;
  logic       scl_up_q;
  logic [1:0] settle_q;

  wire sda_in = sda_s_q[1];
  wire scl_in = scl_s_q[1];
  wire expired = (cnt_q == 7'h00);
  wire start_req = ctrl_q[sc_pkg::CTRL_START_BIT];
  wire in_start = (state_q == sc_pkg::ST_S_WAIT) || (state_q == sc_pkg::ST_S_HOLD)
                  || (state_q == sc_pkg::ST_IDLE && start_req);

  wire start_bad  = (state_q == sc_pkg::ST_IDLE) && start_req && !(sda_in && scl_in);
  wire start_go   = (state_q == sc_pkg::ST_IDLE) && start_req && sda_in && scl_in;
  wire wait_coll  = (state_q == sc_pkg::ST_S_WAIT) && !scl_in;
  // data taken low by another master
  wire wait_early = (state_q == sc_pkg::ST_S_WAIT) && scl_in && !sda_in;
  wire wait_done  = (state_q == sc_pkg::ST_S_WAIT) && scl_in && sda_in && expired;
  // second expiry; clock level ignored here
  wire hold_done  = (state_q == sc_pkg::ST_S_HOLD) && expired;
  wire stop_go    = (state_q == sc_pkg::ST_IDLE) && !start_req && stop_pend_q;
  // release clock once data reads low
  wire rel_done   = (state_q == sc_pkg::ST_P_REL) && !sda_in;
  // clock pulled low while data still held
  wire high_coll  = (state_q == sc_pkg::ST_P_HIGH) && scl_up_q && !scl_in;
  wire high_done  = (state_q == sc_pkg::ST_P_HIGH) && scl_in && expired;
  wire settled    = (settle_q == sc_pkg::SETTLE_CNT);
  wire samp_coll  = (state_q == sc_pkg::ST_P_SAMP) && settled && !sda_in;
  wire samp_done  = (state_q == sc_pkg::ST_P_SAMP) && settled && sda_in;
  wire abort      = start_bad || wait_coll || high_coll || samp_coll;
  wire reload     = start_go || wait_early || wait_done || rel_done
                    || (state_q == sc_pkg::ST_P_HIGH && !scl_in);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sc_pkg::ST_IDLE:   if (start_go) state_d = sc_pkg::ST_S_WAIT;
                         else if (stop_go) state_d = sc_pkg::ST_P_REL;
      sc_pkg::ST_S_WAIT: if (wait_coll) state_d = sc_pkg::ST_IDLE;
                         else if (wait_early || wait_done) state_d = sc_pkg::ST_S_HOLD;
      sc_pkg::ST_S_HOLD: if (hold_done) state_d = sc_pkg::ST_IDLE;
      sc_pkg::ST_P_REL:  if (rel_done) state_d = sc_pkg::ST_P_HIGH;
      sc_pkg::ST_P_HIGH: if (high_coll) state_d = sc_pkg::ST_IDLE;
                         else if (high_done) state_d = sc_pkg::ST_P_SAMP;
      sc_pkg::ST_P_SAMP: if (samp_coll || samp_done) state_d = sc_pkg::ST_IDLE;
      default:           state_d = sc_pkg::ST_IDLE;
    endcase
  end

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    sda_s_q <= rst_i ? 2'h3 : {sda_s_q[0], sda_i};
    scl_s_q <= rst_i ? 2'h3 : {scl_s_q[0], scl_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sc_pkg::ST_IDLE;
      cnt_q   <= sc_pkg::RELOAD_RST;
    end else begin
      state_q <= state_d;
      if (reload) cnt_q <= rate_reload_field_i;
      else if (hold_done) cnt_q <= cnt_q;
      else if (!expired) cnt_q <= cnt_q - 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= sc_pkg::CTRL_RST;
      stop_pend_q <= 1'b0;
    end else begin
      if (ctrl_we_i && !in_start) ctrl_q <= ctrl_wdata_i;
      else if (hold_done || start_bad || wait_coll) ctrl_q[sc_pkg::CTRL_START_BIT] <= 1'b0;
      if (stop_req_i) stop_pend_q <= 1'b1;
      else if (stop_go) stop_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q <= sc_pkg::BUF_RST;
      wclash_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      if (buf_we_i && !in_start) buf_q <= buf_wdata_i;
      wclash_q <= (buf_we_i && in_start) || (wclash_q && !clr_write_clash_i);
      coll_q <= abort || (coll_q && !clr_collision_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      start_seen_q <= 1'b0;
    end else begin
      if (wait_early || wait_done) begin
        sda_low_q <= 1'b1;
        start_seen_q <= 1'b1;
      end else if (abort || samp_done) sda_low_q <= 1'b0;
      else if (stop_go) sda_low_q <= 1'b1;
      else if (high_done) sda_low_q <= 1'b0;
      if (samp_done) start_seen_q <= 1'b0;
      if (hold_done) scl_low_q <= 1'b1;
      else if (rel_done || abort) scl_low_q <= 1'b0;
    end
  end

  // clock seen high; released data settles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_up_q <= 1'b0;
      settle_q <= 2'h0;
    end else begin
      scl_up_q <= (state_q == sc_pkg::ST_P_HIGH) && (scl_up_q || scl_in);
      settle_q <= (state_q == sc_pkg::ST_P_SAMP) ? settle_q + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_d != sc_pkg::ST_IDLE);
    end
  end

  assign master_control_two_o = ctrl_q;
  assign shift_buffer_o = buf_q;
  assign start_seen_o = start_seen_q;
  assign collision_flag_o = coll_q;
  assign write_clash_flag_o = wclash_q;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_q;
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_START_LOAD: assert property (start_go |=> state_q == sc_pkg::ST_S_WAIT)
    else $error("start did not begin counting");
  AST_START_SEEN: assert property (wait_done |=> sda_oe_o && start_seen_o)
    else $error("start not driven");
  AST_REQ_CLEAR: assert property (hold_done |=> !start_req && sda_oe_o)
    else $error("request not cleared");
  AST_COLL_START: assert property (start_bad |=> collision_flag_o && !sda_oe_o)
    else $error("start collision missed");
  AST_WCLASH: assert property (buf_we_i && in_start |=> write_clash_flag_o
    && $stable(shift_buffer_o))
    else $error("write clash missed");
  AST_CTRL_LOCK: assert property (ctrl_we_i && state_q == sc_pkg::ST_S_HOLD
    && !hold_done |=> $stable(master_control_two_o))
    else $error("control changed during start");
  AST_EARLY: assert property (wait_early |=> sda_oe_o && state_q == sc_pkg::ST_S_HOLD)
    else $error("early assert missed");
  AST_NO_COLL_HOLD: assert property (state_q == sc_pkg::ST_S_HOLD && !coll_q
    |=> !collision_flag_o || clr_collision_i)
    else $error("collision in second count");
  AST_STOP_STRETCH: assert property (state_q == sc_pkg::ST_P_HIGH && !scl_up_q
    && !coll_q |=> !collision_flag_o)
    else $error("clock stretch taken as collision");
  AST_SCL_LOW: assert property (hold_done |=> scl_oe_o)
    else $error("clock not driven low");
  AST_STOP_COLL: assert property (samp_coll |=> collision_flag_o)
    else $error("stop collision missed");
  AST_STOP_SCL: assert property (high_coll |=> collision_flag_o ##1 !busy_o)
    else $error("stop clock collision missed");
  AST_STICKY: assert property (coll_q && !clr_collision_i |=> coll_q)
    else $error("flag lost");
  COV_START: cover property (hold_done);
  COV_EARLY: cover property (wait_early);
  COV_STOP: cover property (samp_done);
  COV_COLL: cover property (start_bad);
endmodule
`default_nettype wire

// File: tb/bus_peer.sv
// open-drain two-wire bus with pull-ups and a second master
// assumes enables high mean the pin is pulled low
`timescale 1ns/10ps
`default_nettype none
module bus_peer (
  // design pin enables
  input  wire logic sda_oe_i,
  input  wire logic scl_oe_i,
  // second master pulls
  input  wire logic hold_sda_i,
  input  wire logic hold_scl_i,
  // resolved lines
  output logic      sda_o,
  output logic      scl_o
);
  // wired-and, released lines float high
  assign sda_o = !(sda_oe_i || hold_sda_i);
  assign scl_o = !(scl_oe_i || hold_scl_i);
endmodule
`default_nettype wire

// File: tb/test_i2c_master_start_stop_collision.sv
// bench for the start/stop generator with collision detection
// assumes bus_peer resolves the open-drain lines
`timescale 1ns/10ps
`default_nettype none
module test_i2c_master_start_stop_collision;
  logic       clk_i, rst_i, bwe, hs, hc, ss, cf, wf, bz, sda_oe, scl_oe, sda, scl;
  logic       sdo, sco;
  logic [6:0] rl, r;
  logic [4:0] cwd, mc;
  logic [7:0] bwd, sb, sb_exp, v;
  logic [3:0] pl;
  int         fails, total_checks, n, i;
  start_stop_gen dut_u (.clk_i(clk_i), .rst_i(rst_i), .rate_reload_field_i(rl),
    .ctrl_we_i(pl[0]), .ctrl_wdata_i(cwd), .stop_req_i(pl[1]), .buf_we_i(bwe),
    .buf_wdata_i(bwd), .clr_collision_i(pl[2]), .clr_write_clash_i(pl[3]),
    .master_control_two_o(mc), .shift_buffer_o(sb), .start_seen_o(ss),
    .collision_flag_o(cf), .write_clash_flag_o(wf), .busy_o(bz), .sda_i(sda),
    .scl_i(scl), .sda_o(sdo), .sda_oe_o(sda_oe), .scl_o(sco), .scl_oe_o(scl_oe));
  bus_peer peer_u (.sda_oe_i(sda_oe), .scl_oe_i(scl_oe), .hold_sda_i(hs),
    .hold_scl_i(hc), .sda_o(sda), .scl_o(scl));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // bound for one countdown: sync, reload plus one, slack
  function automatic int span(input logic [6:0] rv);
    return int'(rv) + 6;
  endfunction
  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int sel, input int lim);
    logic c;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      c = sel == 0 ? sda_oe : sel == 1 ? scl_oe : sel == 2 ? cf : sel == 5 ? !scl_oe
        : (!sda_oe && !bz);
      n++;
    end while (c !== 1'b1 && n < lim);
    if (c !== 1'b1) begin
      fails++;
      $display("BAD wait %0d exp 1 seen 0", sel);
      end_sim();
    end
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge clk_i);
    pl <= p;
    @(posedge clk_i);
    pl <= 4'h0;
  endtask
  task automatic go(input logic [6:0] rv);
    @(posedge clk_i);
    rl <= rv;
    cwd <= 5'h01;
    pulse(4'h1);
  endtask
  initial begin
    rst_i = 1'b1;
    {bwe, hs, hc, pl, rl, cwd, bwd} = '0;
    void'($urandom(32'h3283));
    sb_exp = sc_pkg::BUF_RST;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      r = 7'($urandom_range(12, 1));
      v = 8'($urandom);
      go(r);
      @(posedge clk_i);
      bwe <= 1'b1;
      bwd <= v;
      cwd <= 5'h1E;
      pl <= 4'h1;
      @(posedge clk_i);
      bwe <= 1'b0;
      pl <= 4'h0;
      wt(0, span(r));
      chk("start_seen", {7'h0, ss}, 8'h01);
      chk("sda_timing", {7'h0, n + 2 > r}, 8'h01);
      wt(1, span(r));
      chk("ctrl_after", {3'h0, mc}, 8'h00);
      chk("sda_held", {7'h0, sda_oe}, 8'h01);
      chk("buf_kept", sb, sb_exp);
      chk("clash_set", {7'h0, wf}, 8'h01);
      pulse(4'h8);
      #1;
      chk("clash_clr", {7'h0, wf}, 8'h00);
      pulse(4'h2);
      wt(3, 2 * span(r));
      chk("stop_end", {5'h0, scl_oe, cf, ss}, 8'h00);
      chk("drive_lvl", {6'h0, sdo, sco}, 8'h00);
      @(posedge clk_i);
      bwe <= 1'b1;
      @(posedge clk_i);
      bwe <= 1'b0;
      #1;
      sb_exp = v;
      chk("buf_idle", sb, sb_exp);
    end
    hc <= 1'b1;
    go(7'h05);
    wt(2, 12);
    chk("abort_start", {5'h0, sda_oe, bz, mc[0]}, 8'h00);
    hc <= 1'b0;
    pulse(4'h4);
    #1;
    chk("col_clr", {7'h0, cf}, 8'h00);
    go(7'h64);
    repeat (10) @(posedge clk_i);
    hs <= 1'b1;
    wt(0, 8);
    hs <= 1'b0;
    hc <= 1'b1;
    repeat (8) @(posedge clk_i);
    hc <= 1'b0;
    wt(1, span(7'h64));
    chk("no_col", {7'h0, cf}, 8'h00);
    pulse(4'h2);
    wt(5, 20);
    repeat (6) @(posedge clk_i);
    hc <= 1'b1;
    wt(2, 12);
    hc <= 1'b0;
    chk("stop_clk_col", {7'h0, cf}, 8'h01);
    pulse(4'h4);
    wt(3, 12);
    go(7'h04);
    wt(1, 30);
    hs <= 1'b1;
    pulse(4'h2);
    wt(2, 40);
    chk("stop_sda_col", {7'h0, cf}, 8'h01);
    hs <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
